// ---- rtl/smspi_frames.sv ----
// Serial command and readback frame logic of one stackable monitor device.
//
// What this block does
// RL1 - Mode 1 slave: serial clock idles low, bits taken on second edge.
// RL2 - Incoming serial data is sampled on every serial clock falling edge while chip select is low.
// RL3 - Outgoing serial data changes on every serial clock rising edge while chip select is low.
// RL4 - Only 32-bit frames; bit counter clears when chip select rises.
// RL5 - Host keeps chip select low across all 32 bits of a frame.
// RL6 - Write to control upper byte starts conversions at chip select rise.
// RL7 - Write: address 31-27, register 26-21, data 20-13, all 12, zero 11.
// RL8 - Device address is zero after reset until assigned.
// RL9 - Device address field travels least significant bit first.
// RL10 - Register, channel, data and CRC fields travel MSB first.
// RL11 - Register addresses are six bits, register data eight bits.
// RL12 - Address-all flag makes every device execute the write.
// RL13 - CRC over bits 31-11 sits in 10-3; mismatch discards the write.
// RL14 - Lowest three bits must be 010 or the write is refused.
// RL15 - Bit 10 of next frame is high when the last write executed.
// RL16 - Result frame: address, channel, result, ack, CRC, two zeros.
// RL17 - Register frame: address, register, data, zeros, ack, CRC, zeros.
// RL18 - Read CRC covers bits 31-10 and goes out in bits 9-2.
// RL19 - Host keeps sending valid writes to a high address during readback.
// RL20 - Chain readback takes conversions times devices frames.
// RL21 - One write frame updates any register of any chained device.
// RL22 - Nonzero read select returns a register, zero returns results.
// RL23 - Host loads read select nonzero so acknowledges relay properly.
// RL24 - A frame with other than 32 clocks is discarded unexecuted.
`include "smspi_params.svh"
`default_nettype none

module smspi_frames (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    csN,
   input  wire logic                    sclk,
   input  wire logic                    sdi,
   output var  logic                    sdo,
   input  wire logic                    devAddrLoad,
   input  wire smspi_pkg::smspi_dev_t   devAddrNew,
   output var  smspi_pkg::smspi_dev_t   devAddr,
   input  wire smspi_pkg::smspi_reg_t   readSel,
   input  wire smspi_pkg::smspi_data_t  regRdData,
   input  wire smspi_pkg::smspi_chan_t  resultChan,
   input  wire smspi_pkg::smspi_result_t resultData,
   output var  logic                    resultTake,
   output var  logic                    cmdValid,
   input  wire logic                    cmdReady,
   output var  smspi_pkg::smspi_reg_t   cmdReg,
   output var  smspi_pkg::smspi_data_t  cmdData,
   output var  logic                    writeAck,
   output var  logic                    convStart
);
   import smspi_pkg::*;

   // =========================================================
   // Helper functions
   // =========================================================

   // Reverses the five address bits, which travel LSB first.
   function automatic smspi_dev_t bitRev5(input smspi_dev_t a);
      smspi_dev_t r;
      r = '0;
      for (int i = 0; i < 5; i++) begin
         r[i] = a[4 - i];
      end
      return r;
   endfunction : bitRev5

   // CRC-8 over the top n bits of d, processed MSB first.
   function automatic smspi_data_t crc8(input logic [21:0] d,
                                        input int          n);
      smspi_data_t c;
      logic        fb;
      c  = `SMSPI_CRC_INIT;
      fb = 1'b0;
      for (int i = 21; i >= 0; i--) begin
         if (i > 21 - n) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0};
            if (fb) begin
               c = c ^ `SMSPI_CRC_POLY;
            end
         end
      end
      return c;
   endfunction : crc8

   // =========================================================
   // Pin synchronisers and edge detection
   // =========================================================

   logic [2:0] sclkSync_r;
   logic [2:0] csSync_r;
   logic [1:0] sdiSync_r;

   // Two flip-flops on each pin, a third stage only for edges.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclkSync_r <= 3'h0;
         csSync_r   <= 3'h7;
         sdiSync_r  <= 2'h0;
      end else begin
         sclkSync_r <= {sclkSync_r[1:0], sclk};
         csSync_r   <= {csSync_r[1:0], csN};
         sdiSync_r  <= {sdiSync_r[0], sdi};
      end
   end

   logic sclkFall;
   logic sclkRise;
   logic csFall;
   logic csRise;
   logic csActive;

   // Edges of the link clock and chip select in the local domain.
   assign sclkFall = sclkSync_r[2] & ~sclkSync_r[1];    // [RL1]
   assign sclkRise = ~sclkSync_r[2] & sclkSync_r[1];
   assign csFall   = csSync_r[2] & ~csSync_r[1];
   assign csRise   = ~csSync_r[2] & csSync_r[1];
   assign csActive = ~csSync_r[1];

   // =========================================================
   // Receive shift register and bit counter
   // =========================================================

   smspi_frame_t rx_r;
   logic [5:0]   bitCnt_r;

   // Shifts in one bit per falling edge inside the frame.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_r <= '0;
      end else if (csActive && sclkFall) begin
         rx_r <= {rx_r[30:0], sdiSync_r[1]};            // [RL2] [RL10]
      end
   end

   // Counts clocks of the frame, saturating, cleared at chip select rise.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bitCnt_r <= 6'd0;
      end else if (csRise || csFall) begin
         bitCnt_r <= 6'd0;                              // [RL4]
      end else if (csActive && sclkFall &&
                   bitCnt_r != `SMSPI_CNT_SAT) begin
         bitCnt_r <= bitCnt_r + 6'd1;
      end
   end

   // =========================================================
   // Write frame decode and checks
   // =========================================================

   smspi_dev_t  rxDev;
   smspi_reg_t  rxReg;
   smspi_data_t rxData;
   logic        rxAll;
   logic        crcOk;
   logic        patOk;
   logic        lenOk;
   logic        forMe;
   logic        bufFull;
   logic        execWr;
   smspi_dev_t  devAddr_r;

   // Field split of a completed write frame.
   assign rxDev  = bitRev5(rx_r[31:27]);                // [RL7] [RL9]
   assign rxReg  = rx_r[26:21];                         // [RL11]
   assign rxData = rx_r[20:13];
   assign rxAll  = rx_r[12];
   assign crcOk  = crc8({rx_r[31:11], 1'b0}, 21) == rx_r[10:3]; // [RL13]
   assign patOk  = rx_r[2:0] == `SMSPI_PATTERN;         // [RL14]
   assign lenOk  = bitCnt_r == `SMSPI_FRAME_BITS;       // [RL24]

   // A write for all devices or for this address alone.
   assign forMe  = rxAll || (rxDev == devAddr_r);       // [RL12] [RL21]

   // Executes at the closing chip select edge when all checks pass.
   assign execWr = csRise && lenOk && forMe && crcOk && patOk && !bufFull;

   // =========================================================
   // Device address
   // =========================================================

   // Zero after reset; loaded by the address assignment logic.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         devAddr_r <= `SMSPI_DEV_ADDR_RST;              // [RL8]
      end else if (devAddrLoad) begin
         devAddr_r <= devAddrNew;
      end
   end

   assign devAddr = devAddr_r;

   // =========================================================
   // Write acknowledge and conversion start
   // =========================================================

   logic ack_r;
   logic convStart_r;

   // Ack follows each complete frame that targets this device.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else if (csRise && lenOk && forMe) begin
         ack_r <= execWr;                               // [RL15]
      end
   end

   // One pulse when the control upper byte is written.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         convStart_r <= 1'b0;
      end else begin
         convStart_r <= execWr && rxReg == `SMSPI_CTRL_HI_ADDR; // [RL6]
      end
   end

   assign writeAck  = ack_r;
   assign convStart = convStart_r;

   // =========================================================
   // Two-entry command buffer
   // =========================================================

   logic        headV_r;
   smspi_reg_t  headReg_r;
   smspi_data_t headData_r;
   logic        holdV_r;
   smspi_reg_t  holdReg_r;
   smspi_data_t holdData_r;
   logic        pop;

   assign pop     = headV_r && cmdReady;
   assign bufFull = headV_r && holdV_r;

   // Head slot drives the outputs; the hold slot absorbs a stall.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         headV_r    <= 1'b0;
         headReg_r  <= '0;
         headData_r <= '0;
         holdV_r    <= 1'b0;
         holdReg_r  <= '0;
         holdData_r <= '0;
      end else if (pop) begin
         if (holdV_r) begin
            headReg_r  <= holdReg_r;
            headData_r <= holdData_r;
            holdV_r    <= execWr;
            holdReg_r  <= rxReg;
            holdData_r <= rxData;
         end else begin
            headV_r    <= execWr;
            headReg_r  <= rxReg;
            headData_r <= rxData;
         end
      end else if (execWr) begin
         if (!headV_r) begin
            headV_r    <= 1'b1;
            headReg_r  <= rxReg;
            headData_r <= rxData;
         end else begin
            holdV_r    <= 1'b1;
            holdReg_r  <= rxReg;
            holdData_r <= rxData;
         end
      end
   end

   assign cmdValid = headV_r;
   assign cmdReg   = headReg_r;
   assign cmdData  = headData_r;

   // =========================================================
   // Readback frame build and transmit
   // =========================================================

   logic [21:0]  rdHead;
   smspi_frame_t rdFrame;
   smspi_frame_t tx_r;
   logic         sdo_r;
   logic         take_r;
   logic         regMode;

   // Register readback when read select is nonzero.
   assign regMode = readSel != `SMSPI_READ_RESULTS;     // [RL22]

   // Upper 22 bits of the outgoing frame, both kinds.
   always_comb begin
      if (regMode) begin
         rdHead = {bitRev5(devAddr_r), readSel, regRdData,
                   2'b00, ack_r};                       // [RL17]
      end else begin
         rdHead = {bitRev5(devAddr_r), resultChan, resultData,
                   ack_r};                              // [RL16]
      end
   end

   // Appends the read CRC over bits 31 to 10 and two zero bits.
   assign rdFrame = {rdHead, crc8(rdHead, 22), 2'b00};  // [RL18]

   // Loads at frame start, shifts out on each rising edge.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_r  <= '0;
         sdo_r <= 1'b0;
      end else if (csFall) begin
         tx_r  <= rdFrame;
         sdo_r <= 1'b0;
      end else if (csActive && sclkRise) begin
         sdo_r <= tx_r[31];                             // [RL3] [RL10]
         tx_r  <= {tx_r[30:0], 1'b0};
      end else if (!csActive) begin
         sdo_r <= 1'b0;
      end
   end

   // Advances the result sequence once per result frame.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         take_r <= 1'b0;
      end else begin
         take_r <= csFall && !regMode;                  // [RL20]
      end
   end

   assign sdo        = sdo_r;
   assign resultTake = take_r;

endmodule : smspi_frames
`default_nettype wire

// ---- rtl/smspi_params.svh ----
// Constants of the stack monitor serial frame block.
`ifndef SMSPI_PARAMS_SVH
`define SMSPI_PARAMS_SVH
`define SMSPI_FRAME_BITS    6'd32
`define SMSPI_CNT_SAT       6'd33
`define SMSPI_PATTERN       3'h2
`define SMSPI_CRC_POLY      8'h2f
`define SMSPI_CRC_INIT      8'h00
`define SMSPI_DEV_ADDR_RST  5'h00
`define SMSPI_CTRL_HI_ADDR  6'h0d
`define SMSPI_READ_RESULTS  6'h00
`endif

// ---- rtl/smspi_pkg.sv ----
// Types shared by the stack monitor serial frame block.
`default_nettype none
package smspi_pkg;
   typedef logic [4:0]  smspi_dev_t;
   typedef logic [5:0]  smspi_reg_t;
   typedef logic [7:0]  smspi_data_t;
   typedef logic [3:0]  smspi_chan_t;
   typedef logic [11:0] smspi_result_t;
   typedef logic [31:0] smspi_frame_t;
endpackage : smspi_pkg
`default_nettype wire

// ---- tb/smspi_frames_checker.sv ----
// Port checker of the serial frame block.
`default_nettype none
module smspi_frames_checker (
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  csN,
   input wire logic                  sdo,
   input wire logic                  devAddrLoad,
   input wire smspi_pkg::smspi_dev_t devAddrNew,
   input wire smspi_pkg::smspi_dev_t devAddr,
   input wire smspi_pkg::smspi_reg_t readSel,
   input wire logic                  resultTake,
   input wire logic                  cmdValid,
   input wire logic                  cmdReady,
   input wire smspi_pkg::smspi_reg_t cmdReg,
   input wire smspi_pkg::smspi_data_t cmdData,
   input wire logic                  writeAck,
   input wire logic                  convStart
);
   timeunit 1ns;
   timeprecision 100ps;
   import smspi_pkg::*;
   // ==========
   // Properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_reset_clear: assert property ($fell(rst) |->
      !cmdValid && !writeAck && devAddr == 5'h00)
      else $error("State not cleared by reset.");
   a_idle_low: assert property (csN [*6] |-> !sdo)
      else $error("Serial output not low between frames.");
   a_ack_steady: assert property (!csN [*8] |=> $stable(writeAck))
      else $error("Acknowledge changed inside a frame.");
   a_push_acked: assert property ($rose(cmdValid) |-> writeAck && csN)
      else $error("Command pushed without acknowledge.");
   a_head_hold: assert property (cmdValid && !cmdReady |=>
      cmdValid && $stable({cmdReg, cmdData}))
      else $error("Buffer head changed while stalled.");
   a_conv_pulse: assert property (convStart |=> !convStart)
      else $error("Conversion start longer than one cycle.");
   a_take_mode: assert property (resultTake |-> $past(readSel) == 6'h00 ##1 !resultTake)
      else $error("Result taken outside result mode.");
   a_addr_load: assert property (devAddrLoad |=> devAddr == $past(devAddrNew))
      else $error("Device address not loaded.");
endmodule : smspi_frames_checker
`default_nettype wire

// ---- tb/smspi_host_model.sv ----
// Host side serial master model for the frame block.
`default_nettype none
module smspi_host_model (
   output var logic csN,
   output var logic sclk,
   output var logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle pins: chip select high, clock parked low.
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // One framed transfer of nb clocks ending with tx[0], 125 ns clock.
   // Clocks above 32 lead with ones; bits read before rx[31] are dropped.
   // The 2 ns lead keeps pin changes off the system clock's edges.
   task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
      rx = '0;
      #2;
      csN = 1'b0;
      #200;
      for (int i = nb - 1; i >= 0; i--) begin
         sclk = 1'b1;
         sdi = i < 32 ? tx[i] : 1'b1;
         #62.5;
         sclk = 1'b0;
         if (i < 32) rx[i] = sdo;
         #62.5;
      end
      #100;
      csN = 1'b1;
      sdi = ~sdi;
      #500;
   endtask : xfer
endmodule : smspi_host_model
`default_nettype wire

// ---- tb/smspi_frames_bench.sv ----
// Self-checking bench of the serial frame block.
`include "smspi_params.svh"
`default_nettype none
module smspi_frames_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import smspi_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, devAddrLoad = 1'b0, cmdReady = 1'b0;
   logic csN, sclk, sdi, sdo, resultTake, cmdValid, writeAck, convStart;
   smspi_dev_t devAddrNew = 5'h00, devAddr;
   smspi_reg_t readSel = 6'h0e, cmdReg;
   smspi_data_t regRdData = 8'h3c, cmdData;
   smspi_chan_t resultChan = 4'h5;
   smspi_result_t resultData = 12'habc;
   int err_count = 0, cmp_count = 0, cyc = 0, convCnt = 0, takeCnt = 0;
   smspi_frames dut (.sys_clk, .rst, .csN, .sclk, .sdi, .sdo, .devAddrLoad, .devAddrNew,
      .devAddr, .readSel, .regRdData, .resultChan, .resultData, .resultTake, .cmdValid,
      .cmdReady, .cmdReg, .cmdData, .writeAck, .convStart);
   smspi_host_model host (.csN, .sclk, .sdi, .sdo);
   // Clock, cycle ceiling and pulse counters.
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (convStart === 1'b1) convCnt++;
      if (resultTake === 1'b1) takeCnt++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end
   // ==========
   // Helpers
   function automatic logic [7:0] crc8(input logic [21:0] v, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = n - 1; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `SMSPI_CRC_POLY : 8'h00);
      return c;
   endfunction : crc8
   function automatic logic [4:0] rev5(input logic [4:0] d);
      for (int i = 0; i < 5; i++) rev5[i] = d[4 - i];
   endfunction : rev5
   function automatic logic [31:0] mkw(input smspi_dev_t d, input smspi_reg_t r,
                                       input smspi_data_t v, input logic a);
      logic [20:0] h;
      h = {rev5(d), r, v, a, 1'b0};
      return {h, crc8({1'b0, h}, 21), `SMSPI_PATTERN};
   endfunction : mkw
   function automatic logic [31:0] rdf(input logic [21:0] p);
      return {p, crc8(p, 22), 2'b00};
   endfunction : rdf
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic pop();
      @(negedge sys_clk) cmdReady = 1'b1;
      @(negedge sys_clk) cmdReady = 1'b0;
   endtask : pop
   // ==========
   // Scenarios
   task automatic t_write();
      logic [31:0] rx;
      chk("devAddr", devAddr, 0);
      host.xfer(mkw(5'h00, `SMSPI_CTRL_HI_ADDR, 8'ha5, 1'b0), 32, rx);
      chk("cmd", {cmdValid, cmdReg, cmdData}, {1'b1, 6'h0d, 8'ha5});
      chk("ack", writeAck, 1);
      chk("conv", convCnt, 1);
      pop();
      $display("t_write done");
   endtask : t_write
   task automatic t_refuse();
      logic [31:0] rx, w, e;
      // Bad CRC, bad pattern, a good write behind 33 clocks, and 31 clocks.
      for (int k = 0; k < 4; k++) begin
         w = mkw(5'h00, 6'h01, 8'h11, 1'b0) ^ (k == 0 ? 32'h8 : k == 1 ? 32'h2 : 32'h0);
         host.xfer(w, k == 2 ? 33 : k == 3 ? 31 : 32, rx);
         e = rdf({5'h00, 6'h0e, 8'h3c, 2'b00, k == 0});
         chk("rdframe", rx, k == 2 ? e << 1 : k == 3 ? e >> 1 : e);
         chk("refused", {cmdValid, writeAck}, 0);
      end
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_read();
      logic [31:0] rx;
      @(negedge sys_clk) {devAddrLoad, devAddrNew, readSel} = {1'b1, 5'h01, 6'h00};
      @(negedge sys_clk) devAddrLoad = 1'b0;
      host.xfer(mkw(5'h1f, 6'h00, 8'h00, 1'b0), 32, rx);
      chk("result", rx, rdf({5'b10000, 4'h5, 12'habc, 1'b0}));
      chk("take", {takeCnt[1:0], cmdValid}, {2'd1, 1'b0});
      host.xfer(mkw(5'h00, 6'h03, 8'h77, 1'b1), 32, rx);
      chk("all", {cmdValid, writeAck, cmdData}, {2'b11, 8'h77});
      pop();
      readSel = 6'h0e;
      $display("t_read done");
   endtask : t_read
   task automatic t_buffer();
      logic [31:0] rx;
      for (int k = 1; k < 4; k++) host.xfer(mkw(5'h00, 6'h02, k[7:0], 1'b1), 32, rx);
      chk("full", writeAck, 0);
      for (int k = 1; k < 3; k++) begin
         chk("head", {cmdValid, cmdReg, cmdData}, {1'b1, 6'h02, k[7:0]});
         pop();
      end
      chk("empty", {cmdValid, convCnt[1:0]}, {1'b0, 2'd1});
      $display("t_buffer done");
   endtask : t_buffer
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // Reset for six cycles, then the scenarios in turn.
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      repeat (6) @(negedge sys_clk);
      t_write();
      t_refuse();
      t_read();
      t_buffer();
      test_done();
   end
endmodule : smspi_frames_bench
bind smspi_frames smspi_frames_checker mon (.sys_clk, .rst, .csN, .sdo, .devAddrLoad,
   .devAddrNew, .devAddr, .readSel, .resultTake, .cmdValid, .cmdReady, .cmdReg, .cmdData,
   .writeAck, .convStart);
`default_nettype wire
